// file: shared/clbbc_regs.vh
`ifndef CLBBC_REGS_VH
`define CLBBC_REGS_VH
// Transfer width encodings
`define CLBBC_W_LONG 2'h0
`define CLBBC_W_BYTE 2'h1
`define CLBBC_W_WORD 2'h2
`define CLBBC_W_LINE 2'h3
// Request kinds
`define CLBBC_K_READ 3'h0
`define CLBBC_K_WRITE 3'h1
`define CLBBC_K_LREAD 3'h2
`define CLBBC_K_LWRITE 3'h3
// Request purposes
`define CLBBC_P_NORMAL 2'h0
`define CLBBC_P_MOVE 2'h1
`define CLBBC_P_FILL 2'h2
`define CLBBC_P_PUSH 2'h3
// Beats in one line
`define CLBBC_LINE_BEATS 3'h4
// Data FIFO depth
`define CLBBC_FIFO_DEPTH 16
`endif

// file: rtl/clbbc_fifo.v
`timescale 1ns/1ns
`default_nettype none
module clbbc_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  // Full and empty come straight from the occupancy count
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Storage write, flip-flops by index
  always @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // Pointers and count
  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        // Compared, not sliced, so any depth wraps at its own last slot
        wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // clbbc_fifo
`default_nettype wire

// file: rtl/clbbc_lanes.v
`timescale 1ns/1ns
`default_nettype none
module clbbc_lanes (
  // Transfer shape
  input wire [1:0] width,
  input wire [1:0] addr_lo,
  // Byte lanes that carry data, bit 3 is the top lane
  output reg [3:0] lanes
);
  // Lane map follows big-endian byte placement on the bus
  always @* begin
    lanes = 4'h0;
    case (width)
      2'h1: begin
        lanes = 4'h8 >> addr_lo;
      end
      2'h2: begin
        lanes = addr_lo[1] ? 4'h3 : 4'hc;
      end
      default: begin
        lanes = 4'hf;
      end
    endcase
  end
endmodule // clbbc_lanes
`default_nettype wire

// file: rtl/clbbc_seq.v
// Notes on behaviour
// R1: First clock of line read drives address, attributes and line width code.
// R2: Memory supplies read data afterwards, first beat at addressed long word.
// R3: Sample ack and refuse inputs each clock; wait until ack, then latch.
// R4: First line-read beat passes data and cache-refuse level to control unit.
// R5: Refused line read finishes as three long-word reads with A3:A2 advanced.
// R6: Memory advances A3:A2 itself during bursts; attributes held steady.
// R7: Burst beats two to four each wait for ack and latch their word.
// R8: Cache-refuse input is ignored on every write cycle.
// R9: Single write: start pulse with address, then only valid lanes driven.
// R10: Memory finds valid lanes from direction, width, A1:A0, uncached flag.
// R11: Single write waits for ack, then releases the bus and ends.
// R12: Single writes serve uncached, write-through, stacking, refused and lone pushes.
// R13: Line transfers serve block move, cache fill and cache push.
// R14: Line write starts with line width code, then all lanes valid.
// R15: Line write samples ack and burst-refuse each clock until ack.
// R16: Refused line write ends as three long-word writes, A3:A2 advanced.
// R17: Burst write beats drive next word with attributes held.
// R18: Indivisible flag stays high through the whole locked sequence.
// R19: Arbiter may withhold grants while indivisible flag is high.
// R20: Locked access is uncached; any push runs first, flag may rise early.
// R21: Locked transfers only for test-and-set and compare-and-swap kinds. The code takes req_locked with any req_kind, line reads included.
// R22: Burst-refuse ignored after the first beat of a line transfer.
// R23: Refused line beats stay one transfer; no arbitration between them.
// R24: Memory wraps its A3:A2 advance inside the aligned line.
// R25: Memory ignores A1:A0 on long-word and line reads.
`timescale 1ns/1ns
`default_nettype none
`include "clbbc_regs.vh"
module clbbc_seq #(
  parameter DW = 32,
  parameter AW = 32
) (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Request from the core
  input wire req_valid,
  output wire req_ready,
  input wire [2:0] req_kind,
  input wire [1:0] req_width,
  input wire [1:0] req_purpose,
  input wire [AW-1:0] req_addr,
  input wire req_cached,
  input wire req_locked,
  input wire req_lock_end,
  // Write data into the burst buffer
  input wire wdata_valid,
  output wire wdata_ready,
  input wire [DW-1:0] wdata,
  // Read data to the access control unit
  output reg ctl_valid,
  output reg [DW-1:0] ctl_data,
  output reg ctl_first,
  output reg ctl_cache_refuse,
  output reg done,
  // Multiplexed bus
  output reg [DW-1:0] bus_out,
  output reg [3:0] bus_oe,
  input wire [DW-1:0] bus_in,
  // Bus control
  output reg transfer_start_n,
  output reg rd_wr,
  output reg [1:0] transfer_width,
  output reg uncached_flag_n,
  output reg indivisible_flag_n,
  output reg bus_hold,
  input wire cycle_ack_n,
  input wire burst_refuse_n,
  input wire cache_refuse_n
);
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_DATA = 3'h2;
  localparam S_NEXT = 3'h3;
  reg [2:0] state_q;
  reg [2:0] kind_q;
  reg [1:0] width_q;
  reg [AW-1:0] addr_q;
  reg [2:0] beat_q;
  reg refused_q;
  reg lock_q;
  wire [3:0] lanes;
  wire f_valid;
  wire [DW-1:0] f_data;
  wire f_pop;
  wire is_write;
  wire is_line;
  wire ack;
  wire last_beat;

  assign is_write = kind_q[0];
  assign is_line = kind_q[1];
  // An ack seen while the start pulse is still out belongs to no beat
  assign ack = (state_q == S_DATA) && transfer_start_n && !cycle_ack_n;
  assign last_beat = !is_line || (beat_q == `CLBBC_LINE_BEATS - 3'h1);
  // A write waits for its first word, so the bus never starts unfed
  assign req_ready = (state_q == S_IDLE) &&
    (req_kind[0] ? f_valid : 1'b1);
  // Each acked write beat consumes one buffered word
  assign f_pop = ack && is_write;

  // Write data buffer; the core stalls on wdata_ready when it fills
  clbbc_fifo #(.WIDTH(DW), .DEPTH(`CLBBC_FIFO_DEPTH), .AW(4)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(wdata_valid),
    .in_ready(wdata_ready),
    .in_data(wdata),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // Valid byte lanes for single writes
  clbbc_lanes u_lanes (
    .width(width_q),
    .addr_lo(addr_q[1:0]),
    .lanes(lanes)
  );

  // Bus sequencer
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      kind_q <= 3'h0;
      width_q <= 2'h0;
      addr_q <= {AW{1'b0}};
      beat_q <= 3'h0;
      refused_q <= 1'b0;
      lock_q <= 1'b0;
      ctl_valid <= 1'b0;
      ctl_data <= {DW{1'b0}};
      ctl_first <= 1'b0;
      ctl_cache_refuse <= 1'b0;
      done <= 1'b0;
      bus_out <= {DW{1'b0}};
      bus_oe <= 4'h0;
      transfer_start_n <= 1'b1;
      rd_wr <= 1'b1;
      transfer_width <= 2'h0;
      uncached_flag_n <= 1'b1;
      indivisible_flag_n <= 1'b1;
      bus_hold <= 1'b0;
    end else begin
      ctl_valid <= 1'b0;
      ctl_first <= 1'b0;
      done <= 1'b0;
      transfer_start_n <= 1'b1;
      case (state_q)
        S_IDLE: begin
          bus_oe <= 4'h0;
          if (req_valid && req_ready) begin
            kind_q <= req_kind;
            // Line kinds carry the line code on the width pins until a refusal
            width_q <= req_kind[1] ? `CLBBC_W_LINE : req_width; // R1 R14
            addr_q <= req_addr;
            beat_q <= 3'h0;
            refused_q <= 1'b0;
            // Locked access forced uncached; push, if any, precedes it
            uncached_flag_n <= !(req_locked || !req_cached); // R20 R12
            // Flag rises at lock start, may already cover a push
            if (req_locked) begin
              lock_q <= 1'b1; // R18 R21
            end
            // Line transfers for move, fill and push
            bus_hold <= req_kind[1] &&
              (req_purpose != `CLBBC_P_NORMAL); // R13 R23
            state_q <= S_ADDR;
          end
        end
        S_ADDR: begin
          // Address clock: start pulse, address and attributes
          transfer_start_n <= 1'b0; // R1 R9 R14
          rd_wr <= !is_write;
          transfer_width <= (is_line && !refused_q) ? `CLBBC_W_LINE :
            (refused_q ? `CLBBC_W_LONG : width_q);
          bus_out <= addr_q;
          bus_oe <= 4'hf;
          indivisible_flag_n <= !lock_q; // R18
          state_q <= S_DATA;
        end
        S_DATA: begin
          // Data phase; reads release the bus, writes drive lanes
          if (is_write) begin
            bus_out <= f_data; // R17
            bus_oe <= (is_line || refused_q) ? 4'hf : lanes; // R9 R14
          end else begin
            bus_oe <= 4'h0;
          end
          // Wait states until ack; cache refuse only read on line reads
          if (ack) begin // R3 R7 R11 R15
            if (!is_write) begin
              ctl_valid <= 1'b1;
              ctl_data <= bus_in; // R3
              ctl_first <= (beat_q == 3'h0);
              if (beat_q == 3'h0) begin
                ctl_cache_refuse <= is_line && !cache_refuse_n; // R4 R8
              end
            end
            // Refusal seen only with the first beat's ack
            if (is_line && beat_q == 3'h0 && !burst_refuse_n) begin // R22
              refused_q <= 1'b1; // R5 R16
            end
            beat_q <= beat_q + 3'h1;
            if (last_beat) begin
              state_q <= S_IDLE;
              bus_oe <= 4'h0; // R11
              bus_hold <= 1'b0;
              done <= 1'b1;
              if (req_lock_end) begin
                lock_q <= 1'b0;
                indivisible_flag_n <= 1'b1;
              end
            end else if ((beat_q == 3'h0 && !burst_refuse_n) || refused_q) begin
              // Separate long-word cycles, A3:A2 advanced by the device
              addr_q[3:2] <= addr_q[3:2] + 2'h1; // R5 R16
              bus_hold <= 1'b1; // R23
              state_q <= S_NEXT;
            end
          end
        end
        S_NEXT: begin
          // Dead clock between refused beats, bus released
          bus_oe <= 4'h0;
          state_q <= S_ADDR;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // clbbc_seq
`default_nettype wire

// file: test/clbbc_seq_sva.sv
`timescale 1ns/1ns
`default_nettype none
module clbbc_seq_sva (
  // Clock, reset and bus side
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cycle_ack_n,
  input wire logic cache_refuse_n,
  input wire logic [31:0] bus_in,
  input wire logic transfer_start_n,
  input wire logic rd_wr,
  input wire logic [1:0] transfer_width,
  input wire logic [3:0] bus_oe,
  // Core side
  input wire logic ctl_valid,
  input wire logic ctl_first,
  input wire logic ctl_cache_refuse,
  input wire logic [31:0] ctl_data,
  input wire logic done
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Bus phases and data hand-off
  AST_START_PULSE: assert property
    (!transfer_start_n |=> transfer_start_n)
    else $error("start held longer than one cycle");
  AST_ADDR_DRIVE: assert property (!transfer_start_n |-> bus_oe == 4'hf)
    else $error("address not on all lanes");
  AST_RD_RELEASE: assert property
    (!transfer_start_n && rd_wr |=> bus_oe == 4'h0)
    else $error("read did not release the bus");
  AST_LINE_LANES: assert property
    (!transfer_start_n && !rd_wr && transfer_width == 2'h3
      |=> bus_oe == 4'hf)
    else $error("line write lanes not all driven");
  AST_ATTR_HOLD: assert property
    (transfer_start_n |-> $stable(transfer_width) && $stable(rd_wr))
    else $error("attributes moved inside a transfer");
  AST_ACK_TO_CTL: assert property
    (ctl_valid |-> $past(cycle_ack_n) == 1'b0)
    else $error("read beat without ack");
  AST_CTL_LATCH: assert property
    (ctl_valid |-> ctl_data == $past(bus_in))
    else $error("read beat data not latched at ack");
  AST_FIRST_REFUSE: assert property (ctl_first && transfer_width == 2'h3
    |-> ctl_cache_refuse == !$past(cache_refuse_n))
    else $error("cache refuse level not forwarded");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  // Main scenarios
  C_REFUSE: cover property (ctl_first && ctl_cache_refuse);
  C_LWRITE: cover property
    (!transfer_start_n && !rd_wr && transfer_width == 2'h3);
  C_LONG_READ: cover property
    (!transfer_start_n && rd_wr && transfer_width == 2'h0);
  C_WDONE: cover property (done && !rd_wr);
endmodule // clbbc_seq_sva
`default_nettype wire

// file: test/clbbc_mem.sv
`timescale 1ns/1ns
`default_nettype none
module clbbc_mem (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus from the sequencer
  input wire logic [31:0] bus_out,
  input wire logic transfer_start_n,
  input wire logic [1:0] transfer_width,
  // Behaviour knobs
  input wire logic [2:0] waits,
  input wire logic refuse,
  input wire logic nocache,
  // Responses
  output logic cycle_ack_n,
  output logic burst_refuse_n,
  output logic cache_refuse_n,
  output logic [31:0] bus_in
);
  logic [31:0] a;
  logic [2:0] left;
  logic [2:0] w;
  logic first;
  // Acks are single-cycle; data lines toggle when not answering
  always @(posedge mclk) begin
    cycle_ack_n <= 1'b1;
    burst_refuse_n <= 1'b1;
    cache_refuse_n <= 1'b1;
    bus_in <= ~bus_in;
    if (!rst_n) begin
      left <= 3'h0;
      bus_in <= 32'h0;
    end else if (!transfer_start_n) begin
      a <= bus_out;
      left <= (transfer_width == 2'h3) ? 3'h4 : 3'h1;
      w <= waits;
      first <= (transfer_width == 2'h3);
    end else if (left != 3'h0) begin
      if (w != 3'h0) begin
        w <= w - 3'h1;
      end else if (cycle_ack_n) begin
        cycle_ack_n <= 1'b0;
        bus_in <= {a[31:2], 2'h0} ^ 32'ha5c30000;
        // Without refusal, later beats carry a stray refuse to be ignored
        burst_refuse_n <= (refuse != first);
        cache_refuse_n <= !(nocache && first);
      end else begin
        // A refused line waits for the device's next start pulse
        left <= (refuse && first) ? 3'h0 : left - 3'h1;
        a[3:2] <= a[3:2] + 2'h1;
        w <= waits;
        first <= 1'b0;
      end
    end
  end
endmodule // clbbc_mem
`default_nettype wire

// file: test/clbbc_seq_tb.sv
`timescale 1ns/1ns
`default_nettype none
module clbbc_seq_tb;
  logic mclk = 0, rst_n = 0, req_valid = 0, req_locked = 0, req_lock_end = 0;
  logic [2:0] req_kind = 0, m_w = 0;
  logic [1:0] req_width = 0;
  logic [1:0] req_purpose = 0;
  logic req_cached = 1;
  logic [31:0] req_addr = 0, wdata = 0, bus_out, bus_in, ctl_data;
  logic wdata_valid = 0, m_r = 0, m_c = 0, req_ready, wdata_ready, ctl_valid;
  logic ctl_first, ctl_cache_refuse, done, transfer_start_n, rd_wr;
  logic uncached_flag_n, indivisible_flag_n, bus_hold, cycle_ack_n;
  logic burst_refuse_n, cache_refuse_n;
  logic [3:0] bus_oe;
  logic [1:0] transfer_width;
  // Read data pattern of the memory model
  localparam logic [31:0] PAT = 32'ha5c30000;
  integer errors = 0, n_tests = 0, k = 0;
  clbbc_seq i_dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_kind(req_kind), .req_width(req_width),
    .req_purpose(req_purpose), .req_addr(req_addr), .req_cached(req_cached),
    .req_locked(req_locked), .req_lock_end(req_lock_end),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .wdata(wdata),
    .ctl_valid(ctl_valid), .ctl_data(ctl_data), .ctl_first(ctl_first),
    .ctl_cache_refuse(ctl_cache_refuse), .done(done), .bus_out(bus_out),
    .bus_oe(bus_oe), .bus_in(bus_in), .transfer_start_n(transfer_start_n),
    .rd_wr(rd_wr), .transfer_width(transfer_width), .bus_hold(bus_hold),
    .uncached_flag_n(uncached_flag_n), .indivisible_flag_n(indivisible_flag_n),
    .cycle_ack_n(cycle_ack_n), .burst_refuse_n(burst_refuse_n),
    .cache_refuse_n(cache_refuse_n));
  clbbc_mem i_mem (.mclk(mclk), .rst_n(rst_n), .bus_out(bus_out),
    .transfer_start_n(transfer_start_n), .transfer_width(transfer_width),
    .waits(m_w), .refuse(m_r), .nocache(m_c), .cycle_ack_n(cycle_ack_n),
    .burst_refuse_n(burst_refuse_n), .cache_refuse_n(cache_refuse_n),
    .bus_in(bus_in));
  // 10 MHz clock
  initial begin
    forever #50 mclk = ~mclk;
  end
  task wrap_up;
    begin
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    begin
      n_tests++;
      if (s !== e) begin
        errors++;
        $display("mismatch at %0t: got %h expected %h", $time, s, e);
      end
    end
  endtask
  // Polls at falling edges so settled values are seen; bounded
  task wait_on(input integer which);
    integer i;
    begin
      i = 0;
      do begin
        @(negedge mclk);
        i++;
        if (i > 80) begin
          errors++;
          wrap_up;
        end
      end while (!((which == 0 && cycle_ack_n === 1'b0) ||
        (which == 1 && ctl_valid === 1'b1) ||
        (which == 2 && req_ready === 1'b1)));
    end
  endtask
  task put(input logic [2:0] kd, input logic [1:0] wd, input logic [31:0] ad,
    input logic lk, input logic le);
    begin
      @(posedge mclk);
      {req_valid, req_kind, req_width, req_addr} <= {1'b1, kd, wd, ad};
      {req_locked, req_lock_end} <= {lk, le};
    end
  endtask
  task take;
    begin
      if (req_ready !== 1'b1) wait_on(2);
      @(posedge mclk);
      req_valid <= 0;
    end
  endtask
  // Line read: data order, first-beat flags, hold and uncached level
  task line_read(input logic [31:0] ad, input logic r, input logic c,
    input logic lk);
    integer b;
    begin
      {m_r, m_c} = {r, c};
      put(3'h2, 2'h0, ad, lk, 1'b0);
      take;
      for (b = 0; b < 4; b++) begin
        wait_on(1);
        chk(ctl_data, {ad[31:4], ad[3:2] + b[1:0], 2'h0} ^ PAT);
        chk(ctl_first, b == 0);
        chk(bus_hold, (r || req_purpose != 2'h0) && b < 3);
        if (b == 0) chk(ctl_cache_refuse, c);
      end
      chk(uncached_flag_n, !lk);
      chk(transfer_width, r ? 2'h0 : 2'h3);
    end
  endtask
  // Line write: words in buffer order, all lanes, width per beat
  task line_write(input logic [31:0] ad, input logic r, input logic c);
    integer b;
    begin
      {m_r, m_c} = {r, c};
      put(3'h3, 2'h0, ad, 1'b0, 1'b0);
      take;
      for (b = 0; b < 4; b++) begin
        wait_on(0);
        chk(bus_out, 32'hc0de0000 | k);
        chk(bus_oe, 4'hf);
        chk(transfer_width, (r && b > 0) ? 2'h0 : 2'h3);
        chk(rd_wr, 0);
        chk(ctl_valid, 0);
        k++;
      end
      // Earlier reads left the level low; a write must not raise it
      chk(ctl_cache_refuse, 0);
    end
  endtask
  // Sixteen words fill the buffer, which then refuses more
  task fill_fifo;
    integer i;
    begin
      for (i = 0; i < 16; i++) begin
        @(posedge mclk);
        {wdata_valid, wdata} <= {1'b1, 32'hc0de0000 | i};
      end
      @(posedge mclk);
      wdata_valid <= 0;
      @(negedge mclk);
      chk(wdata_ready, 0);
    end
  endtask
  // Byte write ending the locked sequence; held off until data arrives
  task locked_write;
    begin
      put(3'h1, 2'h1, 32'h00008001, 1'b0, 1'b1);
      repeat (3) @(negedge mclk);
      chk(req_ready, 0);
      @(posedge mclk);
      {wdata_valid, wdata} <= {1'b1, 32'h00aa0000};
      @(posedge mclk);
      wdata_valid <= 0;
      take;
      wait_on(0);
      chk(bus_oe, 4'h4);
      chk(bus_out, 32'h00aa0000);
      chk(indivisible_flag_n, 0);
      repeat (3) @(negedge mclk);
      chk(bus_oe, 4'h0);
      chk(indivisible_flag_n, 1);
    end
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1;
    fill_fifo;
    m_w = 3'h2;
    line_read(32'h00001008, 0, 1, 0);
    line_read(32'h0000200c, 1, 0, 0);
    line_write(32'h00003004, 0, 1);
    line_write(32'h00004000, 1, 0);
    m_w = 3'h0;
    line_write(32'h00005000, 0, 0);
    line_write(32'h00006000, 1, 1);
    @(posedge mclk);
    req_purpose <= 2'h1;
    line_read(32'h00007000, 0, 0, 1);
    chk(indivisible_flag_n, 0);
    locked_write;
    wrap_up;
  end
endmodule // clbbc_seq_tb
bind clbbc_seq clbbc_seq_sva i_sva (.mclk(mclk), .rst_n(rst_n),
  .cycle_ack_n(cycle_ack_n), .cache_refuse_n(cache_refuse_n), .bus_in(bus_in),
  .transfer_start_n(transfer_start_n), .rd_wr(rd_wr), .bus_oe(bus_oe),
  .transfer_width(transfer_width), .ctl_valid(ctl_valid), .done(done),
  .ctl_first(ctl_first), .ctl_cache_refuse(ctl_cache_refuse),
  .ctl_data(ctl_data));
`default_nettype wire
